// File: logic/jbs_pkg.sv
// constants for the test access port and boundary-scan chain
package jbs_pkg;
	localparam int          IR_W      = 4;
	localparam int          N_IN      = 4;
	localparam int          N_IO      = 96;
	localparam int          N_MC      = 128;
	localparam int          IO_STAGES = 3;
	localparam int          IO_BASE   = N_IN;
	localparam int          MC_BASE   = IO_BASE + IO_STAGES * N_IO;
	localparam int          CHAIN_LEN = MC_BASE + N_MC;
	localparam int          ID_W      = 32;
	localparam int          PROG_W    = 32;
	// instruction codes
	localparam logic [3:0]  IR_EXTEST = 4'h0;
	localparam logic [3:0]  IR_SAMPLE = 4'h1;
	localparam logic [3:0]  IR_IDCODE = 4'h2;
	localparam logic [3:0]  IR_PROG   = 4'h8;
	localparam logic [3:0]  IR_BYPASS = 4'hf;
	localparam logic [3:0]  IR_CAPT   = 4'h1;
	// identity value is arbitrary, lsb fixed at one
	localparam logic [31:0] ID_VALUE  = 32'h0a5a_5001;

	typedef enum logic [15:0] {
		ST_RESET   = 16'h0001,
		ST_IDLE    = 16'h0002,
		ST_SEL_DR  = 16'h0004,
		ST_CAP_DR  = 16'h0008,
		ST_SH_DR   = 16'h0010,
		ST_EX1_DR  = 16'h0020,
		ST_PAU_DR  = 16'h0040,
		ST_EX2_DR  = 16'h0080,
		ST_UPD_DR  = 16'h0100,
		ST_SEL_IR  = 16'h0200,
		ST_CAP_IR  = 16'h0400,
		ST_SH_IR   = 16'h0800,
		ST_EX1_IR  = 16'h1000,
		ST_PAU_IR  = 16'h2000,
		ST_EX2_IR  = 16'h4000,
		ST_UPD_IR  = 16'h8000
	} jbs_state_e;
endpackage

// File: logic/jbs_port.sv
// test access port controller, boundary-scan chain and programming register
`timescale 1ns/1ns
// Functional notes
// - controller starts in test-logic-reset on power-up reset; no separate test reset.
// - supports sample/preload, external test, bypass and identification instructions.
// - every input pin and every I/O pin owns a boundary-scan cell.
// - I/O cell has three capture stages and two update stages.
// - pin cells and macrocell cells are two distinct variants.
// - cells chain serially through capture stages from test input to test output.
// - capture stages sample live signals, shift, then load update stages.
// - capture, shift and update strobes come from the controller, not pins.
// - with the port disabled, the four test pins act as user I/O.
// - programming uses only the four test pins under the standard access mechanism.
// - pull-up on mode-select and test data input is a configuration choice.
module jbs_port (
	input  wire logic                       clk,
	input  wire logic                       reset_n,
	input  wire logic                       cfg_port_en,
	input  wire logic                       cfg_pullup_en,
	input  wire logic                       tck,
	input  wire logic                       tms,
	input  wire logic                       tdi,
	output logic                            tdo_ff,
	output logic                            tdo_oe_ff,
	input  wire logic                       user_tdo_out,
	input  wire logic                       user_tdo_oe,
	output logic [3:0]                      user_pins_ff,
	output logic                            pullup_en_ff,
	input  wire logic [jbs_pkg::N_IN-1:0]   in_pin,
	input  wire logic [jbs_pkg::N_IO-1:0]   io_pin,
	input  wire logic [jbs_pkg::N_IO-1:0]   core_out,
	input  wire logic [jbs_pkg::N_IO-1:0]   core_oe,
	input  wire logic [jbs_pkg::N_MC-1:0]   mc_val,
	output logic [jbs_pkg::N_IO-1:0]        io_out_ff,
	output logic [jbs_pkg::N_IO-1:0]        io_oe_ff,
	output logic [jbs_pkg::PROG_W-1:0]      prog_data_ff,
	output logic                            prog_wr_ff
);
	localparam int L = jbs_pkg::CHAIN_LEN;

	// two-stage synchronisers for pins from outside the clock domain
	logic [2:0]                   pin_s1_ff, pin_s2_ff;
	logic                         tck_d_ff;
	logic [jbs_pkg::N_IN-1:0]     in_s1_ff, in_s2_ff;
	logic [jbs_pkg::N_IO-1:0]     io_s1_ff, io_s2_ff;
	logic [jbs_pkg::N_MC-1:0]     mc_s1_ff, mc_s2_ff;

	jbs_pkg::jbs_state_e          st_ff, nxt_st;
	logic [3:0]                   ir_sh_ff, nxt_ir_sh;
	logic [3:0]                   ir_ff, nxt_ir;
	logic                         byp_ff, nxt_byp;
	logic [31:0]                  id_ff, nxt_id;
	logic [31:0]                  prg_sh_ff, nxt_prg_sh;
	logic [L-1:0]                 cap_ff, nxt_cap;
	logic [jbs_pkg::N_IO-1:0]     upd_out_ff, nxt_upd_out;
	logic [jbs_pkg::N_IO-1:0]     upd_oe_ff, nxt_upd_oe;
	logic                         nxt_tdo, nxt_tdo_oe;
	logic [jbs_pkg::N_IO-1:0]     nxt_io_out, nxt_io_oe;
	logic [31:0]                  nxt_prog_data;
	logic                         nxt_prog_wr;
	logic [3:0]                   nxt_user;
	logic [L-1:0]                 cap_src;
	logic                         tck_s, tms_s, tdi_s, rise, fall;

	assign tck_s = pin_s2_ff[0];
	assign tms_s = pin_s2_ff[1];
	assign tdi_s = pin_s2_ff[2];
	// edges found from the synchronised copy only; tck is far slower than clk
	assign rise  = tck_s & ~tck_d_ff;
	assign fall  = ~tck_s & tck_d_ff;

	// live values seen by each cell's capture stages
	assign cap_src[jbs_pkg::N_IN-1:0] = in_s2_ff;
	genvar gi;
	generate
		for (gi = 0; gi < jbs_pkg::N_IO; gi++) begin : g_io
			assign cap_src[jbs_pkg::IO_BASE + 3*gi]     = io_s2_ff[gi];
			assign cap_src[jbs_pkg::IO_BASE + 3*gi + 1] = core_out[gi];
			assign cap_src[jbs_pkg::IO_BASE + 3*gi + 2] = core_oe[gi];
			assign nxt_upd_out[gi] = (st_ff == jbs_pkg::ST_UPD_DR && fall
				&& (ir_ff == jbs_pkg::IR_EXTEST || ir_ff == jbs_pkg::IR_SAMPLE))
				? cap_ff[jbs_pkg::IO_BASE + 3*gi + 1] : upd_out_ff[gi];
			assign nxt_upd_oe[gi] = (st_ff == jbs_pkg::ST_UPD_DR && fall
				&& (ir_ff == jbs_pkg::IR_EXTEST || ir_ff == jbs_pkg::IR_SAMPLE))
				? cap_ff[jbs_pkg::IO_BASE + 3*gi + 2] : upd_oe_ff[gi];
			assign nxt_io_out[gi] = (ir_ff == jbs_pkg::IR_EXTEST && cfg_port_en)
				? upd_out_ff[gi] : core_out[gi];
			assign nxt_io_oe[gi] = (ir_ff == jbs_pkg::IR_EXTEST && cfg_port_en)
				? upd_oe_ff[gi] : core_oe[gi];
		end
	endgenerate
	// macrocell cells: capture stage only, no pin drive
	assign cap_src[L-1:jbs_pkg::MC_BASE] = mc_s2_ff;

	// controller sequence and data registers
	always_comb begin
		nxt_st        = st_ff;
		nxt_ir_sh     = ir_sh_ff;
		nxt_ir        = ir_ff;
		nxt_byp       = byp_ff;
		nxt_id        = id_ff;
		nxt_prg_sh    = prg_sh_ff;
		nxt_cap       = cap_ff;
		nxt_tdo       = tdo_ff;
		nxt_tdo_oe    = tdo_oe_ff;
		nxt_prog_data = prog_data_ff;
		nxt_prog_wr   = 1'b0;
		if (!cfg_port_en) begin
			// port unused: controller parked, tdo pin belongs to the user
			nxt_st     = jbs_pkg::ST_RESET;
			nxt_ir     = jbs_pkg::IR_IDCODE;
			nxt_tdo    = user_tdo_out;
			nxt_tdo_oe = user_tdo_oe;
		end else if (rise) begin
			case (st_ff)
				jbs_pkg::ST_RESET:  nxt_st = tms_s ? jbs_pkg::ST_RESET : jbs_pkg::ST_IDLE;
				jbs_pkg::ST_IDLE:   nxt_st = tms_s ? jbs_pkg::ST_SEL_DR : jbs_pkg::ST_IDLE;
				jbs_pkg::ST_SEL_DR: nxt_st = tms_s ? jbs_pkg::ST_SEL_IR : jbs_pkg::ST_CAP_DR;
				jbs_pkg::ST_CAP_DR: nxt_st = tms_s ? jbs_pkg::ST_EX1_DR : jbs_pkg::ST_SH_DR;
				jbs_pkg::ST_SH_DR:  nxt_st = tms_s ? jbs_pkg::ST_EX1_DR : jbs_pkg::ST_SH_DR;
				jbs_pkg::ST_EX1_DR: nxt_st = tms_s ? jbs_pkg::ST_UPD_DR : jbs_pkg::ST_PAU_DR;
				jbs_pkg::ST_PAU_DR: nxt_st = tms_s ? jbs_pkg::ST_EX2_DR : jbs_pkg::ST_PAU_DR;
				jbs_pkg::ST_EX2_DR: nxt_st = tms_s ? jbs_pkg::ST_UPD_DR : jbs_pkg::ST_SH_DR;
				jbs_pkg::ST_UPD_DR: nxt_st = tms_s ? jbs_pkg::ST_SEL_DR : jbs_pkg::ST_IDLE;
				jbs_pkg::ST_SEL_IR: nxt_st = tms_s ? jbs_pkg::ST_RESET : jbs_pkg::ST_CAP_IR;
				jbs_pkg::ST_CAP_IR: nxt_st = tms_s ? jbs_pkg::ST_EX1_IR : jbs_pkg::ST_SH_IR;
				jbs_pkg::ST_SH_IR:  nxt_st = tms_s ? jbs_pkg::ST_EX1_IR : jbs_pkg::ST_SH_IR;
				jbs_pkg::ST_EX1_IR: nxt_st = tms_s ? jbs_pkg::ST_UPD_IR : jbs_pkg::ST_PAU_IR;
				jbs_pkg::ST_PAU_IR: nxt_st = tms_s ? jbs_pkg::ST_EX2_IR : jbs_pkg::ST_PAU_IR;
				jbs_pkg::ST_EX2_IR: nxt_st = tms_s ? jbs_pkg::ST_UPD_IR : jbs_pkg::ST_SH_IR;
				jbs_pkg::ST_UPD_IR: nxt_st = tms_s ? jbs_pkg::ST_SEL_DR : jbs_pkg::ST_IDLE;
				default:            nxt_st = jbs_pkg::ST_RESET;
			endcase
			// capture and shift happen on the rising edge that leaves the state
			case (st_ff)
				jbs_pkg::ST_CAP_IR: nxt_ir_sh = jbs_pkg::IR_CAPT;
				jbs_pkg::ST_SH_IR:  nxt_ir_sh = {tdi_s, ir_sh_ff[3:1]};
				jbs_pkg::ST_CAP_DR: begin
					nxt_byp = 1'b0;
					nxt_id  = jbs_pkg::ID_VALUE;
					if (ir_ff == jbs_pkg::IR_EXTEST || ir_ff == jbs_pkg::IR_SAMPLE)
						nxt_cap = cap_src;
				end
				jbs_pkg::ST_SH_DR: begin
					case (ir_ff)
						jbs_pkg::IR_EXTEST, jbs_pkg::IR_SAMPLE:
							nxt_cap = {tdi_s, cap_ff[L-1:1]};
						jbs_pkg::IR_IDCODE: nxt_id = {tdi_s, id_ff[31:1]};
						jbs_pkg::IR_PROG:   nxt_prg_sh = {tdi_s, prg_sh_ff[31:1]};
						default:            nxt_byp = tdi_s;
					endcase
				end
				default: nxt_byp = byp_ff;
			endcase
		end else if (fall) begin
			// tdo moves on the falling edge so the tester samples a settled bit
			nxt_tdo_oe = (st_ff == jbs_pkg::ST_SH_DR) || (st_ff == jbs_pkg::ST_SH_IR);
			if (st_ff == jbs_pkg::ST_SH_IR)
				nxt_tdo = ir_sh_ff[0];
			else case (ir_ff)
				jbs_pkg::IR_EXTEST, jbs_pkg::IR_SAMPLE: nxt_tdo = cap_ff[0];
				jbs_pkg::IR_IDCODE: nxt_tdo = id_ff[0];
				jbs_pkg::IR_PROG:   nxt_tdo = prg_sh_ff[0];
				default:            nxt_tdo = byp_ff;
			endcase
			if (st_ff == jbs_pkg::ST_RESET)
				nxt_ir = jbs_pkg::IR_IDCODE;
			if (st_ff == jbs_pkg::ST_UPD_IR) begin
				case (ir_sh_ff)
					jbs_pkg::IR_EXTEST, jbs_pkg::IR_SAMPLE, jbs_pkg::IR_IDCODE,
					jbs_pkg::IR_PROG: nxt_ir = ir_sh_ff;
					default:          nxt_ir = jbs_pkg::IR_BYPASS;
				endcase
			end
			if (st_ff == jbs_pkg::ST_UPD_DR && ir_ff == jbs_pkg::IR_PROG) begin
				nxt_prog_data = prg_sh_ff;
				nxt_prog_wr   = 1'b1;
			end
		end
	end

	// test pins seen as plain user inputs when the port is off
	always_comb begin
		nxt_user = cfg_port_en ? 4'h0 : {1'b0, tdi_s, tms_s, tck_s};
	end

	// power-up reset puts the controller straight into test-logic-reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_s1_ff    <= 3'h0;
			pin_s2_ff    <= 3'h0;
			tck_d_ff     <= 1'b0;
			in_s1_ff     <= '0;
			in_s2_ff     <= '0;
			io_s1_ff     <= '0;
			io_s2_ff     <= '0;
			mc_s1_ff     <= '0;
			mc_s2_ff     <= '0;
			st_ff        <= jbs_pkg::ST_RESET;
			ir_sh_ff     <= 4'h0;
			ir_ff        <= jbs_pkg::IR_IDCODE;
			byp_ff       <= 1'b0;
			id_ff        <= 32'h0;
			prg_sh_ff    <= 32'h0;
			cap_ff       <= '0;
			upd_out_ff   <= '0;
			upd_oe_ff    <= '0;
			tdo_ff       <= 1'b0;
			tdo_oe_ff    <= 1'b0;
			io_out_ff    <= '0;
			io_oe_ff     <= '0;
			prog_data_ff <= 32'h0;
			prog_wr_ff   <= 1'b0;
			user_pins_ff <= 4'h0;
			pullup_en_ff <= 1'b0;
		end else begin
			pin_s1_ff    <= {tdi, tms, tck};
			pin_s2_ff    <= pin_s1_ff;
			tck_d_ff     <= pin_s2_ff[0];
			in_s1_ff     <= in_pin;
			in_s2_ff     <= in_s1_ff;
			io_s1_ff     <= io_pin;
			io_s2_ff     <= io_s1_ff;
			mc_s1_ff     <= mc_val;
			mc_s2_ff     <= mc_s1_ff;
			st_ff        <= nxt_st;
			ir_sh_ff     <= nxt_ir_sh;
			ir_ff        <= nxt_ir;
			byp_ff       <= nxt_byp;
			id_ff        <= nxt_id;
			prg_sh_ff    <= nxt_prg_sh;
			cap_ff       <= nxt_cap;
			upd_out_ff   <= nxt_upd_out;
			upd_oe_ff    <= nxt_upd_oe;
			tdo_ff       <= nxt_tdo;
			tdo_oe_ff    <= nxt_tdo_oe;
			io_out_ff    <= nxt_io_out;
			io_oe_ff     <= nxt_io_oe;
			prog_data_ff <= nxt_prog_data;
			prog_wr_ff   <= nxt_prog_wr;
			user_pins_ff <= nxt_user;
			pullup_en_ff <= cfg_pullup_en;
		end
	end
endmodule

// File: verification/jbs_port_monitor.sv
// checker on the test port pins and drive outputs
`timescale 1ns/1ns
module jbs_port_monitor (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        cfg_port_en,
	input wire logic        cfg_pullup_en,
	input wire logic        tck,
	input wire logic        user_tdo_out,
	input wire logic        user_tdo_oe,
	input wire logic        tdo_ff,
	input wire logic        tdo_oe_ff,
	input wire logic [3:0]  user_pins_ff,
	input wire logic        pullup_en_ff,
	input wire logic [95:0] core_out,
	input wire logic [95:0] core_oe,
	input wire logic [95:0] io_out_ff,
	input wire logic [95:0] io_oe_ff,
	input wire logic [31:0] prog_data_ff,
	input wire logic        prog_wr_ff
);
	logic [2:0] quiet_ff, nxt_quiet;
	logic [1:0] dis_ff, nxt_dis;
	logic       tck_ff, nxt_tck;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// quiet counts clocks without a tck change; six leaves room for the sync pipeline
	always_comb begin
		nxt_tck = tck;
		nxt_dis = cfg_port_en ? 2'h0 : dis_ff + {1'b0, dis_ff != 2'h3};
		nxt_quiet = (tck != tck_ff || !cfg_port_en) ? 3'h0 : quiet_ff + {2'h0, quiet_ff != 3'h7};
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			quiet_ff <= 3'h0;
			dis_ff <= 2'h0;
			tck_ff <= 1'b0;
		end else begin
			quiet_ff <= nxt_quiet;
			dis_ff <= nxt_dis;
			tck_ff <= nxt_tck;
		end
	end
	AST_PULLUP: assert property (
		pullup_en_ff == $past(cfg_pullup_en)) else $error("pull-up enable lags config");
	AST_USER_TDO: assert property (
		dis_ff >= 2'h2 |-> tdo_ff == $past(user_tdo_out) && tdo_oe_ff == $past(user_tdo_oe))
		else $error("tdo not from core while port off");
	AST_USER_PINS_OFF: assert property (
		dis_ff == 2'h0 && $past(cfg_port_en) |-> user_pins_ff == 4'h0) else $error("user pins live");
	AST_CORE_PASS: assert property (
		dis_ff >= 2'h2 |-> io_out_ff == $past(core_out) && io_oe_ff == $past(core_oe))
		else $error("pin drive not from core");
	AST_PROG_PULSE: assert property (
		prog_wr_ff |=> !prog_wr_ff) else $error("program strobe too long");
	AST_PROG_LOAD: assert property (
		$changed(prog_data_ff) |-> prog_wr_ff) else $error("program data moved without strobe");
	AST_PROG_IDLE: assert property (
		dis_ff != 2'h0 |-> !prog_wr_ff) else $error("program strobe with port off");
	AST_QUIET: assert property (
		quiet_ff >= 3'h6 |-> $stable(tdo_ff) && $stable(tdo_oe_ff) && !prog_wr_ff)
		else $error("test output moved without tck");
	cover property (prog_wr_ff);
	cover property ($rose(tdo_oe_ff));
	cover property (dis_ff == 2'h2);
endmodule
bind jbs_port jbs_port_monitor u_mon (.clk, .reset_n, .cfg_port_en, .cfg_pullup_en, .tck,
	.user_tdo_out, .user_tdo_oe, .tdo_ff, .tdo_oe_ff, .user_pins_ff, .pullup_en_ff, .core_out,
	.core_oe, .io_out_ff, .io_oe_ff, .prog_data_ff, .prog_wr_ff);

// File: verification/jbs_port_tb.sv
// self-checking bench for the test access port
`timescale 1ns/1ns
module jbs_port_tb;
	logic         clk, reset_n, cfg_port_en, cfg_pullup_en, user_tdo_out, user_tdo_oe;
	logic         tck, tms, tdi, tdo_ff, tdo_oe_ff, prog_wr_ff, pullup_en_ff;
	logic [3:0]   in_pin, user_pins_ff;
	logic [95:0]  io_pin, core_out, core_oe, io_out_ff, io_oe_ff;
	logic [127:0] mc_val;
	logic [31:0]  prog_data_ff;
	logic [419:0] din, dout;
	wire          tdo_pin = tdo_oe_ff ? tdo_ff : ~tdo_ff;
	int           seed = 64495;
	int           mismatches = 0;
	int           checks = 0;
	int           prog_wr_cnt = 0;
	jbs_port u_dut (.clk, .reset_n, .cfg_port_en, .cfg_pullup_en, .tck, .tms, .tdi, .tdo_ff,
		.tdo_oe_ff, .user_tdo_out, .user_tdo_oe, .user_pins_ff, .pullup_en_ff, .in_pin, .io_pin,
		.core_out, .core_oe, .mc_val, .io_out_ff, .io_oe_ff, .prog_data_ff, .prog_wr_ff);
	jbs_tester u_tst (.tck, .tms, .tdi, .tdo(tdo_pin));
	task automatic cmp(input logic [419:0] got, input logic [419:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic note(input string s);
		$display("%s finished, %0d mismatches", s, mismatches);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic pins();
		@(negedge clk);
		in_pin = 4'($random(seed));
		user_tdo_out = 1'($random(seed));
		for (int i = 0; i < 4; i++) begin
			mc_val[i*32 +: 32] = $random(seed);
			if (i < 3) begin
				io_pin[i*32 +: 32] = $random(seed);
				core_out[i*32 +: 32] = $random(seed);
				core_oe[i*32 +: 32] = $random(seed);
			end
		end
	endtask
	function automatic logic [419:0] rnd();
		logic [419:0] e;
		for (int i = 0; i < 420; i++) begin
			e[i] = 1'($random(seed));
		end
		return e;
	endfunction
	function automatic logic [419:0] cap();
		logic [419:0] e;
		e = {mc_val, 288'h0, in_pin};
		for (int i = 0; i < 96; i++) begin
			e[4 + 3 * i +: 3] = {core_oe[i], core_out[i], io_pin[i]};
		end
		return e;
	endfunction
	function automatic logic [419:0] drv(input logic [419:0] d);
		logic [419:0] e;
		e = '0;
		for (int i = 0; i < 96; i++) begin
			e[i] = d[5 + 3 * i];
			e[96 + i] = d[6 + 3 * i];
		end
		return e;
	endfunction
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// strobe counted mid-cycle, away from the edge that launches it
	always @(negedge clk) begin
		if (prog_wr_ff === 1'b1) begin
			prog_wr_cnt++;
		end
	end
	initial begin
		#400000;
		mismatches++;
		end_sim();
	end
	initial begin
		{reset_n, cfg_pullup_en, user_tdo_out, user_tdo_oe, in_pin, mc_val} = '0;
		{io_pin, core_out, core_oe} = '0;
		cfg_port_en = 1'b1;
		repeat (20) @(posedge clk);
		pins();
		reset_n = 1'b1;
		u_tst.treset();
		u_tst.scan(1'b0, 32, '0, dout);
		cmp(dout, 420'(jbs_pkg::ID_VALUE));
		note("idcode");
		// an undefined code has to fall back to the one-bit path
		for (int k = 0; k < 2; k++) begin
			din = rnd();
			u_tst.scan(1'b1, 4, k ? 420'h5 : 420'hf, dout);
			cmp(dout, 420'(jbs_pkg::IR_CAPT));
			u_tst.scan(1'b0, 33, din, dout);
			cmp(dout, 420'({din[31:0], 1'b0}));
		end
		note("bypass");
		din = rnd();
		u_tst.scan(1'b1, 4, 420'(jbs_pkg::IR_PROG), dout);
		u_tst.scan(1'b0, 32, din, dout);
		cmp(420'(prog_data_ff), 420'(din[31:0]));
		cmp(420'(prog_wr_cnt), 420'(1));
		note("program");
		din = rnd();
		pins();
		u_tst.scan(1'b1, 4, 420'(jbs_pkg::IR_SAMPLE), dout);
		u_tst.scan(1'b0, 420, din, dout);
		cmp(dout, cap());
		cmp(420'({io_oe_ff, io_out_ff}), 420'({core_oe, core_out}));
		u_tst.scan(1'b1, 4, 420'(jbs_pkg::IR_EXTEST), dout);
		pins();
		repeat (2) @(negedge clk);
		cmp(420'({io_oe_ff, io_out_ff}), drv(din));
		din = rnd();
		u_tst.scan(1'b0, 420, din, dout);
		repeat (2) @(negedge clk);
		cmp(420'({io_oe_ff, io_out_ff}), drv(din));
		note("sample extest");
		reset_n = 1'b0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		pins();
		repeat (2) @(negedge clk);
		cmp(420'({io_oe_ff, io_out_ff}), 420'({core_oe, core_out}));
		note("reset");
		cfg_port_en = 1'b0;
		cfg_pullup_en = 1'b1;
		user_tdo_oe = 1'b1;
		u_tst.scan(1'b1, 4, 420'(jbs_pkg::IR_EXTEST), dout);
		pins();
		repeat (5) @(negedge clk);
		cmp(420'({tdo_oe_ff, tdo_ff, pullup_en_ff, user_pins_ff}),
			420'({user_tdo_oe, user_tdo_out, 2'b10, tdi, tms, tck}));
		cmp(420'({io_oe_ff, io_out_ff}), 420'({core_oe, core_out}));
		cfg_port_en = 1'b1;
		u_tst.treset();
		u_tst.scan(1'b0, 32, '0, dout);
		cmp(dout, 420'(jbs_pkg::ID_VALUE));
		note("port off");
		cmp(420'(prog_wr_cnt), 420'(1));
		end_sim();
	end
endmodule

// File: verification/jbs_tester.sv
// boundary-scan tester driving the serial link
`timescale 1ns/1ns
module jbs_tester (
	output logic     tck,
	output logic     tms,
	output logic     tdi,
	input wire logic tdo
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// tdo taken late in the cycle, well after the 3 clk answer delay
	task automatic step(input logic m, input logic d, output logic q);
		tck = 1'b0;
		tms = m;
		tdi = d;
		#80 tck = 1'b1;
		#79 q = tdo;
		#1;
	endtask
	task automatic treset();
		logic q;
		for (int i = 0; i < 6; i++) begin
			step(i < 5, 1'b0, q);
		end
		tck = 1'b0;
		// idle gap so the next frame never re-drives a pin in the same step
		#160;
	endtask
	// the extest, sample and bypass codes, the programming code and the undefined code 5 are sent
	task automatic scan(input logic ir, input int n, input logic [419:0] din,
		output logic [419:0] dout);
		logic q;
		dout = '0;
		step(1'b1, 1'b0, q);
		if (ir) begin
			step(1'b1, 1'b0, q);
		end
		step(1'b0, 1'b0, q);
		step(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
		// clock parks low; data line shows junk once released
		tck = 1'b0;
		tdi = ~tdi;
		#160;
	endtask
endmodule
